// file: logic/flr_lock_bits.sv
// Volatile block/sector lock bits with registered read and whole-array set/clear
`timescale 1ns/1ps
`include "flr_cfg.svh"
module flr_lock_bits #(
   parameter int ENTRIES = `FLR_LOCK_ENTRIES
) (
   // Clock and reset
   input  wire logic                flr_clk,
   input  wire logic                rst,
   // Access
   input  wire flr_pkg::flr_idx_t   rd_idx,
   output logic                     rd_data,
   input  wire logic                set_all,
   input  wire logic                clr_all
);
   import flr_pkg::*;

   typedef struct packed {
      logic [ENTRIES-1:0] bits;     // One lock bit per unit
      logic               rd;       // Registered read data
   } flr_lock_t;

   flr_lock_t s, n;

   ////////////////////////////////////////////////////////////////////////
   // Whole-array commands touch every bit in one cycle
   always_comb begin
      n = s;
      if (set_all)
         n.bits = '1;
      else if (clr_all)
         n.bits = '0;
      n.rd = (int'(rd_idx) < ENTRIES) ? s.bits[rd_idx] : `FLR_LOCK_RESET;
   end

   ////////////////////////////////////////////////////////////////////////
   // All units start protected
   always_ff @(posedge flr_clk or posedge rst) begin
      if (rst) begin
         s.bits <= {ENTRIES{`FLR_LOCK_RESET}};
         s.rd   <= `FLR_LOCK_RESET;
      end else begin
         s <= n;
      end
   end

   assign rd_data = s.rd;

endmodule

// file: logic/flr_lock_suspend_ctrl.sv
// Lock-status, whole-chip lock, suspend/resume and software reset command handling
`timescale 1ns/1ps
`include "flr_cfg.svh"
module flr_lock_suspend_ctrl #(
   parameter int SUSP_READY_CYC = `FLR_SUSP_READY_CYC,
   parameter int REC_WRITE_CYC  = `FLR_REC_WRITE_CYC,
   parameter int REC_OTHER_CYC  = `FLR_REC_OTHER_CYC
) (
   // Clock and reset
   input  wire logic       CORE_CLK_I,
   input  wire logic       RST_I,
   // Serial pins
   input  wire logic       CS_N_I,
   input  wire logic       SCLK_I,
   input  wire logic [3:0] SIO_I,
   output logic      [3:0] SIO_O,
   output logic      [3:0] SIO_OE_O,
   // Device configuration and write engine status
   input  wire logic       PROTECT_SCHEME_SELECT_I,
   input  wire logic       QUAD_COMMAND_MODE_I,
   input  wire logic       PERF_ENHANCE_MODE_I,
   input  wire logic       PROGRAM_ACTIVE_I,
   input  wire logic       ERASE_ACTIVE_I,
   // Status
   output logic            WRITE_LATCH_FLAG_O,
   output logic            ERASE_PAUSED_FLAG_O,
   output logic            PROGRAM_PAUSED_FLAG_O,
   output logic            SUSPEND_READY_O,
   output logic            RESET_BUSY_O,
   // Requests to the write engine and the rest of the device
   output logic            SUSPEND_REQ_O,
   output logic            RESUME_REQ_O,
   output logic            SOFT_RESET_O,
   output logic            CMD_STB_O,
   output logic      [7:0] CMD_OP_O
);
   import flr_pkg::*;

   typedef struct packed {
      flr_state_t  st;          // Decoder state
      logic [7:0]  op;          // Opcode of this frame
      logic [23:0] addr;        // Lock-status address
      logic        write_latch_flag;         // Write enable latch
      logic        erase_paused_flag;         // Erase paused
      logic        program_paused_flag;         // Program paused
      logic        armed;       // Reset armed
      logic [15:0] susp_cnt;    // Suspend latency countdown
      logic        susp_rdy;    // Suspend settled
      logic [15:0] rec_cnt;     // Reset recovery countdown
      logic        rec_busy;    // Recovery in progress
      logic        susp_req;    // Pulse to write engine
      logic        res_req;     // Pulse to write engine
      logic        soft_rst;    // Pulse to whole device
      logic        cmd_stb;     // Pass-through command pulse
      logic [7:0]  cmd_op;      // Pass-through opcode
      logic        tx_load;     // Reply load pulse
      logic [7:0]  tx_byte;     // Reply byte
      logic        tx_en;       // Reply drive window
      logic        set_all;     // Lock every unit
      logic        clr_all;     // Unlock every unit
   } flr_ctrl_t;

   flr_ctrl_t s, n;
   flr_link_if lk ();
   flr_idx_t   lock_idx;        // Array index of addressed unit
   logic       lock_bit;        // Registered lock bit
   logic       paused;          // Either suspend flag set
   logic [7:0] b;               // Received byte

   ////////////////////////////////////////////////////////////////////////
   // Commands still honoured while a write is suspended
   function automatic logic allowed_in_suspend(input logic [7:0] op);
      case (op)
         8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hE7, 8'h9F, 8'hAF, 8'h90,
         8'h05, 8'h15, 8'h2B, 8'hB1, 8'hC1, 8'h5A, 8'h3C, 8'h30,
         8'h66, 8'h99, 8'hC0, 8'h35, 8'hF5, 8'h00, 8'hAB: allowed_in_suspend = 1'b1;
         default:                                         allowed_in_suspend = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Edge blocks resolve to 4K sectors, the rest to 64K blocks
   always_comb begin
      if (s.addr[23:16] == `FLR_BLK_BOTTOM)
         lock_idx = `FLR_BOT_SECT_BASE | {5'h00, s.addr[15:12]};
      else if (s.addr[23:16] == `FLR_BLK_TOP)
         lock_idx = `FLR_TOP_SECT_BASE | {5'h00, s.addr[15:12]};
      else
         lock_idx = {1'b0, s.addr[23:16]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoder next state
   always_comb begin
      n          = s;
      n.susp_req = 1'b0;
      n.res_req  = 1'b0;
      n.soft_rst = 1'b0;
      n.cmd_stb  = 1'b0;
      n.tx_load  = 1'b0;
      n.set_all  = 1'b0;
      n.clr_all  = 1'b0;
      paused     = s.erase_paused_flag | s.program_paused_flag;
      b          = lk.rx_byte;

      // Suspend settles after its latency
      if (s.susp_cnt != 16'h0)
         n.susp_cnt = s.susp_cnt - 16'h1;
      n.susp_rdy = paused && (s.susp_cnt == 16'h0);

      // Reset recovery window
      if (s.rec_cnt != 16'h0)
         n.rec_cnt = s.rec_cnt - 16'h1;
      n.rec_busy = (s.rec_cnt != 16'h0);

      // Lock lookup: index settles, then the array read registers
      case (s.st)
         FLR_ST_LOOK1: begin
            n.st = FLR_ST_LOOK2;
         end
         FLR_ST_LOOK2: begin
            n.tx_byte = {7'h00, lock_bit};
            n.tx_load = 1'b1;
            n.tx_en   = 1'b1;
            n.st      = FLR_ST_OUT;
         end
         default: begin
         end
      endcase

      if (lk.byte_stb && !s.rec_busy) begin
         case (s.st)
            FLR_ST_IDLE: begin
               n.op = b;
               // Anything but the reset itself drops an armed reset
               if (b != `FLR_OP_RST)
                  n.armed = 1'b0;
               if (paused && !allowed_in_suspend(b)) begin
                  n.st = FLR_ST_IGNORE;
               end else begin
                  case (b)
                     `FLR_OP_RD_LOCK: begin
                        n.st = PROTECT_SCHEME_SELECT_I ? FLR_ST_ADDR : FLR_ST_IGNORE;
                     end
                     `FLR_OP_LOCK_ALL, `FLR_OP_UNLOCK_ALL: begin
                        // Needs individual mode and a set latch
                        n.st = (PROTECT_SCHEME_SELECT_I && s.write_latch_flag) ? FLR_ST_CMD : FLR_ST_IGNORE;
                     end
                     `FLR_OP_SUSPEND: begin
                        if ((PROGRAM_ACTIVE_I || ERASE_ACTIVE_I) && !paused) begin
                           n.erase_paused_flag      = ERASE_ACTIVE_I;
                           n.program_paused_flag      = PROGRAM_ACTIVE_I && !ERASE_ACTIVE_I;
                           n.write_latch_flag      = 1'b0;
                           n.susp_req = 1'b1;
                           n.susp_cnt = 16'(SUSP_READY_CYC);
                        end
                        n.st = FLR_ST_IGNORE;
                     end
                     `FLR_OP_RESUME, `FLR_OP_RST_ARM, `FLR_OP_RST, `FLR_OP_WRITE_LATCH_SET_CMD: begin
                        n.st = FLR_ST_CMD;
                     end
                     `FLR_OP_NOP: begin
                        n.st = FLR_ST_IGNORE;
                     end
                     default: begin
                        // Other commands belong to the rest of the device
                        n.cmd_stb = 1'b1;
                        n.cmd_op  = b;
                        n.st      = FLR_ST_IGNORE;
                     end
                  endcase
               end
            end
            FLR_ST_ADDR: begin
               n.addr = {s.addr[15:0], b};
               if (lk.byte_cnt == `FLR_ADDR_LAST_BYTE)
                  n.st = FLR_ST_LOOK1;
            end
            FLR_ST_CMD: begin
               // A trailing byte spoils an opcode-only command
               n.st = FLR_ST_IGNORE;
            end
            default: begin
            end
         endcase
      end

      if (lk.frame_end) begin
         if (s.st == FLR_ST_CMD && lk.boundary && lk.byte_cnt == `FLR_OPCODE_ONLY && !s.rec_busy) begin
            case (s.op)
               `FLR_OP_LOCK_ALL: begin
                  n.set_all = 1'b1;
                  n.write_latch_flag     = 1'b0;
               end
               `FLR_OP_UNLOCK_ALL: begin
                  n.clr_all = 1'b1;
                  n.write_latch_flag     = 1'b0;
               end
               `FLR_OP_WRITE_LATCH_SET_CMD: begin
                  n.write_latch_flag = 1'b1;
               end
               `FLR_OP_RESUME: begin
                  // Latch not needed; refused while enhance mode is on
                  if (paused && !PERF_ENHANCE_MODE_I) begin
                     n.erase_paused_flag      = 1'b0;
                     n.program_paused_flag      = 1'b0;
                     n.res_req  = 1'b1;
                     n.susp_cnt = 16'h0;
                  end
               end
               `FLR_OP_RST_ARM: begin
                  n.armed = 1'b1;
               end
               `FLR_OP_RST: begin
                  if (s.armed) begin
                     // Writes in flight or paused are aborted and recover slower
                     n.rec_cnt  = (PROGRAM_ACTIVE_I || ERASE_ACTIVE_I || paused) ?
                                  16'(REC_WRITE_CYC) : 16'(REC_OTHER_CYC);
                     n.rec_busy = 1'b1;
                     n.soft_rst = 1'b1;
                     n.erase_paused_flag      = 1'b0;
                     n.program_paused_flag      = 1'b0;
                     n.write_latch_flag      = 1'b0;
                     n.armed    = 1'b0;
                     n.susp_cnt = 16'h0;
                  end
               end
               default: begin
               end
            endcase
         end
         n.st    = FLR_ST_IDLE;
         n.tx_en = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoder state register
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s    <= '0;
         s.st <= FLR_ST_IDLE;
      end else begin
         s <= n;
      end
   end

   assign lk.quad    = QUAD_COMMAND_MODE_I;
   assign lk.tx_load = s.tx_load;
   assign lk.tx_byte = s.tx_byte;
   assign lk.tx_en   = s.tx_en;

   ////////////////////////////////////////////////////////////////////////
   // Pin front end and lock array
   flr_serial_front u_front (
      .clk      (CORE_CLK_I),
      .rst      (RST_I),
      .cs_n_pin (CS_N_I),
      .sclk_pin (SCLK_I),
      .sio_pin  (SIO_I),
      .sio_out  (SIO_O),
      .sio_oe   (SIO_OE_O),
      .lk       (lk.front)
   );

   flr_lock_bits #(
      .ENTRIES (`FLR_LOCK_ENTRIES)
   ) u_lock (
      .flr_clk (CORE_CLK_I),
      .rst     (RST_I),
      .rd_idx  (lock_idx),
      .rd_data (lock_bit),
      .set_all (s.set_all),
      .clr_all (s.clr_all)
   );

   // Registered status and request outputs
   assign WRITE_LATCH_FLAG_O    = s.write_latch_flag;
   assign ERASE_PAUSED_FLAG_O   = s.erase_paused_flag;
   assign PROGRAM_PAUSED_FLAG_O = s.program_paused_flag;
   assign SUSPEND_READY_O       = s.susp_rdy;
   assign RESET_BUSY_O          = s.rec_busy;
   assign SUSPEND_REQ_O         = s.susp_req;
   assign RESUME_REQ_O          = s.res_req;
   assign SOFT_RESET_O          = s.soft_rst;
   assign CMD_STB_O             = s.cmd_stb;
   assign CMD_OP_O              = s.cmd_op;

endmodule

// file: logic/flr_serial_front.sv
// Serial pin front end: synchronisers, edge detection, byte assembly and reply shifting
`timescale 1ns/1ps
module flr_serial_front (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pins
   input  wire logic       cs_n_pin,
   input  wire logic       sclk_pin,
   input  wire logic [3:0] sio_pin,
   output logic      [3:0] sio_out,
   output logic      [3:0] sio_oe,
   // Decoder side
   flr_link_if.front       lk
);

   typedef struct packed {
      logic       cs_s1, cs_s2, cs_d;    // Chip select sync and delay
      logic       ck_s1, ck_s2, ck_d;    // Serial clock sync and delay
      logic [3:0] io_s1, io_s2;          // Data line sync
      logic [7:0] sh;                    // Receive shifter
      logic [2:0] bits;                  // Bit position in byte
      logic [2:0] bytes;                 // Bytes in frame
      logic       stb, fend, bnd;        // Event outputs
      logic [7:0] tx;                    // Reply shifter
      logic [3:0] out, oe;               // Pin drive
   } flr_front_t;

   flr_front_t s, n;
   logic rise, fall, in_frame;

   ////////////////////////////////////////////////////////////////////////
   // Next state; only the second sync stages feed logic
   always_comb begin
      n = s;
      n.cs_s1 = cs_n_pin;
      n.cs_s2 = s.cs_s1;
      n.cs_d  = s.cs_s2;
      n.ck_s1 = sclk_pin;
      n.ck_s2 = s.ck_s1;
      n.ck_d  = s.ck_s2;
      n.io_s1 = sio_pin;
      n.io_s2 = s.io_s1;
      n.stb   = 1'b0;
      n.fend  = 1'b0;
      rise     = s.ck_s2 & ~s.ck_d;
      fall     = ~s.ck_s2 & s.ck_d;
      in_frame = ~s.cs_s2 & ~s.cs_d;
      // Frame start clears counters
      if (~s.cs_s2 & s.cs_d) begin
         n.bits  = 3'h0;
         n.bytes = 3'h0;
      end else if (s.cs_s2 & ~s.cs_d) begin
         // Frame end: report whether it landed on a byte boundary
         n.fend = 1'b1;
         n.bnd  = (s.bits == 3'h0);
         n.oe   = 4'h0;
      end else if (in_frame && rise) begin
         // Quad takes a nibble per clock, single takes line 0 only
         if (lk.quad) begin
            n.sh   = {s.sh[3:0], s.io_s2};
            n.bits = s.bits + 3'h4;
         end else begin
            n.sh   = {s.sh[6:0], s.io_s2[0]};
            n.bits = s.bits + 3'h1;
         end
         if (n.bits == 3'h0) begin
            n.stb = 1'b1;
            if (s.bytes != 3'h7)
               n.bytes = s.bytes + 3'h1;
         end
      end else if (in_frame && fall && lk.tx_en) begin
         // Reply goes out on the falling edge so it is stable at the next rise
         if (lk.quad) begin
            n.out = s.tx[7:4];
            n.oe  = 4'hF;
            n.tx  = {s.tx[3:0], 4'h0};
         end else begin
            n.out = {2'h0, s.tx[7], 1'b0};
            n.oe  = 4'h2;
            n.tx  = {s.tx[6:0], 1'b0};
         end
      end
      if (lk.tx_load)
         n.tx = lk.tx_byte;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; chip select idles high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s       <= '0;
         s.cs_s1 <= 1'b1;
         s.cs_s2 <= 1'b1;
         s.cs_d  <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign lk.byte_stb  = s.stb;
   assign lk.rx_byte   = s.sh;
   assign lk.byte_cnt  = s.bytes;
   assign lk.frame_end = s.fend;
   assign lk.boundary  = s.bnd;
   assign sio_out      = s.out;
   assign sio_oe       = s.oe;

endmodule

// file: pkg/flr_cfg.svh
// Opcodes, lock-array layout, reset values and timing counts of the lock/suspend/reset controller
`ifndef FLR_CFG_SVH
`define FLR_CFG_SVH

// Opcodes handled here
`define FLR_OP_RD_LOCK    8'h3C
`define FLR_OP_LOCK_ALL   8'h7E
`define FLR_OP_UNLOCK_ALL 8'h98
`define FLR_OP_WRITE_LATCH_SET_CMD       8'h06
`define FLR_OP_SUSPEND    8'hB0
`define FLR_OP_RESUME     8'h30
`define FLR_OP_NOP        8'h00
`define FLR_OP_RST_ARM    8'h66
`define FLR_OP_RST        8'h99

// Lock array: 256 blocks of 64K, then 16 bottom and 16 top 4K sectors
`define FLR_LOCK_ENTRIES  288
`define FLR_BOT_SECT_BASE 9'h100
`define FLR_TOP_SECT_BASE 9'h110
`define FLR_BLK_BOTTOM    8'h00
`define FLR_BLK_TOP       8'hFF
`define FLR_LOCK_RESET    1'b1

// Frame byte counts
`define FLR_ADDR_LAST_BYTE 3'h4
`define FLR_OPCODE_ONLY    3'h1

// Timing
`define FLR_CLK_MHZ       250
`define FLR_SUSP_READY_US 20
`define FLR_SUSP_READY_CYC (`FLR_SUSP_READY_US * `FLR_CLK_MHZ)
`define FLR_REC_WRITE_CYC 400
`define FLR_REC_OTHER_CYC 100

`endif

// file: pkg/flr_link_if.sv
// Byte-level link between the serial front end and the command decoder
`timescale 1ns/1ps
interface flr_link_if;
   logic       quad;        // Four-line command mode
   logic       byte_stb;    // One-cycle pulse: byte complete
   logic [7:0] rx_byte;     // Byte just received
   logic [2:0] byte_cnt;    // Bytes so far in frame, saturating
   logic       frame_end;   // One-cycle pulse: chip select rose
   logic       boundary;    // Chip select rose on a byte boundary
   logic       tx_load;     // Load reply byte
   logic [7:0] tx_byte;     // Reply byte
   logic       tx_en;       // Drive reply on falling edges

   modport front (input quad, tx_load, tx_byte, tx_en,
                  output byte_stb, rx_byte, byte_cnt, frame_end, boundary);
   modport core  (output quad, tx_load, tx_byte, tx_en,
                  input byte_stb, rx_byte, byte_cnt, frame_end, boundary);
endinterface

// file: pkg/flr_pkg.sv
// Types shared by the lock/suspend/reset controller modules
package flr_pkg;

   // Command decoder states
   typedef enum logic [2:0] {
      FLR_ST_IDLE   = 3'b000,
      FLR_ST_ADDR   = 3'b001,
      FLR_ST_LOOK1  = 3'b010,
      FLR_ST_LOOK2  = 3'b011,
      FLR_ST_OUT    = 3'b100,
      FLR_ST_CMD    = 3'b101,
      FLR_ST_IGNORE = 3'b110
   } flr_state_t;

   // Lock array index
   typedef logic [8:0] flr_idx_t;

endpackage

// file: verification/flr_host_model.sv
// Host serial controller model: frames with opcode, address and reply
`timescale 1ns/1ps
module flr_host_model (
   // Mode and pins
   input  wire logic       quad_i,
   output logic            cs_n_o,
   output logic            sclk_o,
   output logic      [3:0] sio_o,
   input  wire logic [3:0] sio_i
);
   logic [3:0] smp; // Lines seen at the last rise
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sio_o = 4'h5;
   end
   // One 125 ns clock; idles low, so it stands still between frames
   task automatic pulse(input logic [3:0] d);
      sio_o = d;
      #62.5 sclk_o = 1'b1;
      smp = sio_i;
      #62.5 sclk_o = 1'b0;
   endtask
   // Byte out MSB first; upper lines toggle as junk in single mode
   task automatic put(input logic [7:0] b);
      if (quad_i) begin
         pulse(b[7:4]);
         pulse(b[3:0]);
      end else
         for (int i = 7; i >= 0; i--) pulse({~{3{b[i]}}, b[i]});
   endtask
   // Reply in; released lines toggle so a floating line never matches by luck
   task automatic get(output logic [7:0] b);
      if (quad_i) begin
         pulse(4'hA);
         b[7:4] = smp;
         pulse(4'h5);
         b[3:0] = smp;
      end else
         for (int i = 7; i >= 0; i--) begin
            pulse(i[0] ? 4'hA : 4'h5);
            b[i] = smp[1];
         end
   endtask
   // Frame: opcode, then address and reply byte when asked, then extra clocks
   task automatic frame(input logic [7:0] op, input logic [23:0] ad, input bit rd,
                        input int xb, output logic [7:0] rx);
      rx = 8'h00;
      cs_n_o = 1'b0;
      #40 put(op);
      if (rd) begin
         for (int k = 2; k >= 0; k--) put(ad[k*8+:8]);
         get(rx);
      end
      repeat (xb) pulse(4'h3);
      #40 cs_n_o = 1'b1;
      #300;
   endtask
endmodule

// file: verification/flr_lock_suspend_ctrl_tb_top.sv
// Self-checking bench for the lock/suspend/reset controller
`timescale 1ns/1ps
module flr_lock_suspend_ctrl_tb_top;
   localparam int SUSP = 50; // Short suspend latency
   logic       clk, rst, quad, prot, perf, pact, eact, cs_n, sclk;
   logic       wl, ef, pf, rdy, rbusy, sreq, rreq, srst, stb;
   logic [3:0] so, soe, hs, si;
   logic [7:0] op, rx;
   int         num_errors, samples_checked, n_srst, n_stb, n_req;
   // Wire level: device where enabled, host elsewhere
   assign si = (soe & so) | (~soe & hs);
   flr_lock_suspend_ctrl #(.SUSP_READY_CYC(SUSP), .REC_WRITE_CYC(10), .REC_OTHER_CYC(5))
   flr_lock_suspend_ctrl_inst (.CORE_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .SIO_I(si),
      .SIO_O(so), .SIO_OE_O(soe), .PROTECT_SCHEME_SELECT_I(prot), .QUAD_COMMAND_MODE_I(quad),
      .PERF_ENHANCE_MODE_I(perf), .PROGRAM_ACTIVE_I(pact), .ERASE_ACTIVE_I(eact),
      .WRITE_LATCH_FLAG_O(wl), .ERASE_PAUSED_FLAG_O(ef), .PROGRAM_PAUSED_FLAG_O(pf),
      .SUSPEND_READY_O(rdy), .RESET_BUSY_O(rbusy), .SUSPEND_REQ_O(sreq), .RESUME_REQ_O(rreq),
      .SOFT_RESET_O(srst), .CMD_STB_O(stb), .CMD_OP_O(op));
   flr_host_model flr_host_model_inst (.quad_i(quad), .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(hs), .sio_i(si));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Pulse counters, since the pulses last one cycle
   always @(posedge clk) begin
      if (srst === 1'b1)
         n_srst++;
      if (stb === 1'b1)
         n_stb++;
      if (sreq === 1'b1 || rreq === 1'b1)
         n_req++;
   end
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      samples_checked++;
      if (got !== ex) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] o);
      flr_host_model_inst.frame(o, 24'h0, 1'b0, 0, rx);
   endtask
   task automatic rdl(input logic [23:0] ad, input logic ex);
      flr_host_model_inst.frame(8'h3C, ad, 1'b1, 0, rx);
      chk("lock bit", {7'h00, ex}, rx);
   endtask
   // Whole-chip lock and unlock, refusals and lock readback
   task automatic s_lock();
      cmd(8'h06);
      cmd(8'h98);
      @(negedge clk) prot = 1'b1;
      rdl(24'h100000, 1'b1);
      cmd(8'h06);
      chk("latch", 8'h01, {7'h00, wl});
      cmd(8'h98);
      chk("latch", 8'h00, {7'h00, wl});
      rdl(24'h120000, 1'b0);
      rdl(24'h003000, 1'b0);
      cmd(8'h06);
      flr_host_model_inst.frame(8'h7E, 24'h0, 1'b0, 4, rx);
      rdl(24'hFFF000, 1'b0);
      cmd(8'h7E);
      rdl(24'h120000, 1'b1);
      @(negedge clk) quad = 1'b1;
      rdl(24'hFFF000, 1'b1);
      @(negedge clk) quad = 1'b0;
   endtask
   // Suspend and resume of erase, then of program
   task automatic s_susp();
      int n;
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         eact = (k == 0);
         pact = (k == 1);
         cmd(8'h06);
         cmd(8'hB0);
         chk("erase flag", {7'h00, eact}, {7'h00, ef});
         chk("program flag", {7'h00, pact}, {7'h00, pf});
         chk("ready", 8'h01, {7'h00, rdy});
         n = n_stb;
         cmd(8'h06);
         cmd(8'h03);
         cmd(8'h02);
         chk("latch", 8'h00, {7'h00, wl});
         chk("strobes", 8'(n + 1), 8'(n_stb));
         chk("opcode", 8'h03, op);
         @(negedge clk) perf = 1'b1;
         cmd(8'h30);
         chk("flags", 8'h01, {7'h00, ef | pf});
         @(negedge clk) perf = 1'b0;
         cmd(8'h30);
         chk("flags", 8'h00, {6'h00, ef, pf});
         chk("requests", 8'(2 * k + 2), 8'(n_req));
         @(negedge clk);
         eact = 1'b0;
         pact = 1'b0;
         repeat (4 * SUSP) @(negedge clk);
      end
      cmd(8'hB0);
      chk("flags", 8'h00, {6'h00, ef, pf});
      chk("requests", 8'h04, 8'(n_req));
   endtask
   // Arm, disarm and full software reset in mid-suspend
   task automatic s_rst();
      int n;
      n = n_srst;
      cmd(8'h66);
      cmd(8'h00);
      cmd(8'h99);
      cmd(8'h66);
      cmd(8'h03);
      cmd(8'h99);
      chk("resets", 8'(n), 8'(n_srst));
      @(negedge clk) eact = 1'b1;
      cmd(8'hB0);
      cmd(8'h66);
      cmd(8'h99);
      chk("resets", 8'(n + 1), 8'(n_srst));
      chk("flags", 8'h00, {6'h00, ef, pf});
      @(negedge clk) eact = 1'b0;
   endtask
   initial begin
      {rst, quad, prot, perf, pact, eact} = 6'h20;
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      chk("idle status", 8'h00, {3'h0, wl, ef, pf, rdy, rbusy});
      s_lock();
      s_susp();
      s_rst();
      complete_run();
   end
   // Hang guard
   initial begin
      #390000 chk("run done", 8'h01, 8'h00);
      complete_run();
   end
endmodule

// file: verification/flr_lsc_props.sv
// Port-level property checker for the lock/suspend/reset controller
`timescale 1ns/1ps
module flr_lsc_props #(
   parameter int SUSP_READY_CYC = 5000
) (
   // Clock, reset and levels
   input wire logic       CORE_CLK_I,
   input wire logic       RST_I,
   input wire logic       PERF_ENHANCE_MODE_I,
   input wire logic       PROGRAM_ACTIVE_I,
   input wire logic       ERASE_ACTIVE_I,
   // Watched outputs
   input wire logic       WRITE_LATCH_FLAG_O,
   input wire logic       ERASE_PAUSED_FLAG_O,
   input wire logic       PROGRAM_PAUSED_FLAG_O,
   input wire logic       SUSPEND_READY_O,
   input wire logic       RESET_BUSY_O,
   input wire logic       SUSPEND_REQ_O,
   input wire logic       RESUME_REQ_O,
   input wire logic       SOFT_RESET_O,
   input wire logic       CMD_STB_O,
   input wire logic [7:0] CMD_OP_O
);
   int   cnt;    // Cycles spent suspended
   logic paused; // Either suspend flag
   assign paused = ERASE_PAUSED_FLAG_O | PROGRAM_PAUSED_FLAG_O;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // Age of the suspension, so the ready point is judged in cycles
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I)
         cnt <= 0;
      else
         cnt <= paused ? cnt + 1 : 0;
   end
   property p_susp; SUSPEND_REQ_O |-> paused && !WRITE_LATCH_FLAG_O; endproperty
   a_susp: assert property (p_susp) else $error("suspend without flag");
   property p_erase; $rose(ERASE_PAUSED_FLAG_O) |-> $past(ERASE_ACTIVE_I); endproperty
   a_erase: assert property (p_erase) else $error("erase flag without erase");
   property p_prog; $rose(PROGRAM_PAUSED_FLAG_O) |-> $past(PROGRAM_ACTIVE_I); endproperty
   a_prog: assert property (p_prog) else $error("program flag without program");
   property p_rdy; $rose(SUSPEND_READY_O) |-> cnt inside {[SUSP_READY_CYC:SUSP_READY_CYC+2]}; endproperty
   a_rdy: assert property (p_rdy) else $error("ready at wrong time");
   property p_rdy_by; paused && cnt == SUSP_READY_CYC + 3 |-> SUSPEND_READY_O; endproperty
   a_rdy_by: assert property (p_rdy_by) else $error("ready late");
   property p_res; RESUME_REQ_O |-> !PERF_ENHANCE_MODE_I ##1 !paused; endproperty
   a_res: assert property (p_res) else $error("bad resume");
   property p_soft; SOFT_RESET_O |=> RESET_BUSY_O && !paused && !WRITE_LATCH_FLAG_O; endproperty
   a_soft: assert property (p_soft) else $error("soft reset left state");
   property p_quiet; RESET_BUSY_O |-> !(CMD_STB_O || SUSPEND_REQ_O || RESUME_REQ_O); endproperty
   a_quiet: assert property (p_quiet) else $error("command during recovery");
   property p_filt;
      CMD_STB_O && paused |-> CMD_OP_O inside {8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hE7, 8'h9F, 8'hAF, 8'h90,
         8'h05, 8'h15, 8'h2B, 8'hB1, 8'hC1, 8'h5A, 8'hC0, 8'h35, 8'hF5, 8'hAB};
   endproperty
   a_filt: assert property (p_filt) else $error("opcode passed while suspended");
   c_rdy: cover property (SUSPEND_READY_O);
   c_res: cover property (RESUME_REQ_O);
   c_soft: cover property (SOFT_RESET_O);
endmodule
bind flr_lock_suspend_ctrl flr_lsc_props #(.SUSP_READY_CYC(SUSP_READY_CYC)) flr_lsc_props_inst (.CORE_CLK_I,
   .RST_I, .PERF_ENHANCE_MODE_I, .PROGRAM_ACTIVE_I, .ERASE_ACTIVE_I, .WRITE_LATCH_FLAG_O,
   .ERASE_PAUSED_FLAG_O, .PROGRAM_PAUSED_FLAG_O, .SUSPEND_READY_O, .RESET_BUSY_O, .SUSPEND_REQ_O,
   .RESUME_REQ_O, .SOFT_RESET_O, .CMD_STB_O, .CMD_OP_O);
